// file: verilog/sst_execute.sv
`timescale 1ns/1ps
module sst_execute
  import sst_pkg::*;
#(
  parameter int FILE_DEPTH = 128
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);
  ////////////////////////////////////////////////////////////////////////
  logic [SST_DATA_W-1:0] file_mem [FILE_DEPTH];
  logic [SST_DATA_W-1:0] dir_reg  [SST_DIR_N];
  logic [SST_DATA_W-1:0] acc;
  logic [SST_OP_W-1:0]   instr;
  logic [SST_FA_W-1:0]   faddr;
  logic                  flag_c;
  logic                  flag_hc;
  logic                  flag_z;
  logic                  illegal;
  sst_state_t            state;
  logic                  ack;
  logic [3:0]            reg_idx;
  logic                  is_sub;
  logic                  is_swap;
  logic                  is_dir;
  logic                  dest_file;
  logic [SST_FA_W-1:0]   op_addr;
  logic [SST_SEL_W-1:0]  op_sel;
  logic [SST_DATA_W-1:0] alu_result;
  logic                  alu_c;
  logic                  alu_hc;
  logic                  alu_z;
  logic                  cycle_end;
  logic                  wr_req;
  logic                  rd_req;
  logic                  exec_req;
  logic                  exec_fin;
  logic                  ans_now;

  assign reg_idx   = avs_address[5:2];
  assign wr_req    = avs_write && !ack;
  assign rd_req    = avs_read && !ack;
  assign exec_req  = wr_req && (reg_idx == SST_REG_INSTR) && (state == SST_IDLE);
  // the held instruction write retires on the last clock of its cycle,
  // otherwise the still-raised write would be taken as a fresh issue
  assign exec_fin  = (state == SST_EXEC) && cycle_end;
  assign ans_now   = ((rd_req || wr_req) && (state == SST_IDLE) && !exec_req) || exec_fin;

  ////////////////////////////////////////////////////////////////////////
  // decode
  assign is_sub    = (instr[SST_OP6_HI:SST_OP6_LO] == SST_OP_SUB);
  assign is_swap   = (instr[SST_OP6_HI:SST_OP6_LO] == SST_OP_SWAP);
  assign is_dir    = (instr[SST_OP6_HI:SST_OP11_LO] == SST_OP_DIR);
  assign dest_file = instr[SST_D_BIT];
  assign op_addr   = instr[SST_FA_W-1:0];
  assign op_sel    = instr[SST_SEL_W-1:0];

  sst_alu u_alu (
    .file_val        (file_mem[op_addr]),
    .acc_val         (acc),
    .do_swap         (is_swap),
    .result          (alu_result),
    .carry           (alu_c),
    .half_carry_flag (alu_hc),
    .zero            (alu_z)
  );

  sst_phase_div #(.PHASES(SST_PHASES)) u_div (
    .clk       (clk),
    .rst       (rst),
    .run       (state == SST_EXEC),
    .cycle_end (cycle_end)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencing: one instruction cycle per issued opcode
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SST_IDLE;
    end else begin
      case (state)
        SST_IDLE: begin
          if (exec_req) begin
            state <= SST_EXEC;
          end
        end
        SST_EXEC: begin
          if (cycle_end) begin
            state <= SST_IDLE;
          end
        end
        default: state <= SST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      instr <= '0;
    end else if (exec_req) begin
      instr <= avs_writedata[SST_OP_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulator
  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= '0;
    end else if (state == SST_EXEC && cycle_end && (is_sub || is_swap) && !dest_file) begin
      acc <= alu_result;
    end else if (wr_req && reg_idx == SST_REG_ACC && state == SST_IDLE) begin
      acc <= avs_writedata[SST_DATA_W-1:0];
    end
  end

  // flags move on subtract or a status write; swap and direction-load leave them
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_c  <= 1'b0;
      flag_hc <= 1'b0;
      flag_z  <= 1'b0;
    end else if (state == SST_EXEC && cycle_end && is_sub) begin
      flag_c  <= alu_c;
      flag_hc <= alu_hc;
      flag_z  <= alu_z;
    end else if (wr_req && reg_idx == SST_REG_STATUS && state == SST_IDLE) begin
      flag_c  <= avs_writedata[SST_ST_C];
      flag_hc <= avs_writedata[SST_ST_HC];
      flag_z  <= avs_writedata[SST_ST_Z];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      illegal <= 1'b0;
    end else if (state == SST_EXEC && cycle_end) begin
      // reserved opcodes do nothing but are reported
      illegal <= !(is_sub || is_swap || is_dir);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // file registers: no reset, plain storage
  always_ff @(posedge clk) begin
    if (state == SST_EXEC && cycle_end && (is_sub || is_swap) && dest_file) begin
      file_mem[op_addr] <= alu_result;
    end else if (wr_req && reg_idx == SST_REG_FDATA && state == SST_IDLE) begin
      file_mem[faddr] <= avs_writedata[SST_DATA_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      faddr <= '0;
    end else if (wr_req && reg_idx == SST_REG_FADDR) begin
      faddr <= avs_writedata[SST_FA_W-1:0];
    end
  end

  // direction registers stay directly writable as well
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < SST_DIR_N; i++) begin
        dir_reg[i] <= SST_DIR_RST;
      end
    end else if (state == SST_EXEC && cycle_end && is_dir) begin
      dir_reg[op_sel] <= acc;
    end else if (wr_req && reg_idx >= SST_REG_DIR0 && state == SST_IDLE) begin
      dir_reg[reg_idx[SST_SEL_W-1:0]] <= avs_writedata[SST_DATA_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one-cycle ack; writes during execution wait it out
  always_ff @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= ans_now;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !ans_now;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (rd_req && state == SST_IDLE) begin
      avs_readdata <= '0;
      case (reg_idx)
        SST_REG_INSTR:  avs_readdata[SST_OP_W-1:0] <= instr;
        SST_REG_ACC:    avs_readdata[SST_DATA_W-1:0] <= acc;
        SST_REG_STATUS: begin
          avs_readdata[SST_ST_C]    <= flag_c;
          avs_readdata[SST_ST_HC]   <= flag_hc;
          avs_readdata[SST_ST_Z]    <= flag_z;
          avs_readdata[SST_ST_ILL]  <= illegal;
        end
        SST_REG_FADDR:  avs_readdata[SST_FA_W-1:0] <= faddr;
        SST_REG_FDATA:  avs_readdata[SST_DATA_W-1:0] <= file_mem[faddr];
        default: begin
          if (reg_idx >= SST_REG_DIR0) begin
            avs_readdata[SST_DATA_W-1:0] <= dir_reg[reg_idx[SST_SEL_W-1:0]];
          end
        end
      endcase
    end
  end
endmodule

// file: verilog/sst_pkg.sv
package sst_pkg;
  localparam int SST_DATA_W = 8;
  localparam int SST_OP_W   = 14;
  localparam int SST_FA_W   = 7;
  localparam int SST_SEL_W  = 3;
  // opcode fields
  localparam int SST_D_BIT   = 7;
  localparam int SST_OP6_HI  = 13;
  localparam int SST_OP6_LO  = 8;
  localparam int SST_OP11_LO = 3;
  localparam logic [5:0]  SST_OP_SUB  = 6'h02;
  localparam logic [5:0]  SST_OP_SWAP = 6'h0E;
  localparam logic [10:0] SST_OP_DIR  = 11'h00C;
  // phases per instruction cycle
  localparam int SST_PHASES = 4;
  // register offsets
  localparam logic [3:0] SST_REG_INSTR  = 4'h0;
  localparam logic [3:0] SST_REG_ACC    = 4'h1;
  localparam logic [3:0] SST_REG_STATUS = 4'h2;
  localparam logic [3:0] SST_REG_FADDR  = 4'h3;
  localparam logic [3:0] SST_REG_FDATA  = 4'h4;
  localparam logic [3:0] SST_REG_DIR0   = 4'h8;
  localparam int SST_DIR_N = 8;
  // status field positions
  localparam int SST_ST_C  = 0;
  localparam int SST_ST_HC = 1;
  localparam int SST_ST_Z  = 2;
  localparam int SST_ST_BUSY = 3;
  localparam int SST_ST_ILL  = 4;
  localparam logic [7:0] SST_DIR_RST = 8'hFF;
  typedef enum logic [1:0] {SST_IDLE, SST_EXEC, SST_DONE} sst_state_t;
endpackage

// file: verilog/sst_phase_div.sv
`timescale 1ns/1ps
module sst_phase_div
  import sst_pkg::*;
#(
  parameter int PHASES = SST_PHASES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      cycle_end
);
  logic [$clog2(PHASES)-1:0] phase;

  // one instruction cycle is PHASES clocks, ending pulse on the last
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      phase     <= '0;
      cycle_end <= 1'b0;
    end else begin
      cycle_end <= (phase == $bits(phase)'(PHASES - 2));
      if (phase == $bits(phase)'(PHASES - 1)) begin
        phase <= '0;
      end else begin
        phase <= phase + 1'b1;
      end
    end
  end
endmodule

// file: verilog/sst_alu.sv
`timescale 1ns/1ps
module sst_alu
  import sst_pkg::*;
(
  input  wire logic [SST_DATA_W-1:0] file_val,
  input  wire logic [SST_DATA_W-1:0] acc_val,
  input  wire logic                  do_swap,
  output logic      [SST_DATA_W-1:0] result,
  output logic                       carry,
  output logic                       half_carry_flag,
  output logic                       zero
);
  logic [SST_DATA_W:0] diff;
  logic [4:0]          low_diff;

  always_comb begin
    // two's complement: f + ~w + 1, carry out means no borrow
    diff     = {1'b0, file_val} + {1'b0, ~acc_val} + 9'h001;
    low_diff = {1'b0, file_val[3:0]} + {1'b0, ~acc_val[3:0]} + 5'h01;
    if (do_swap) begin
      result = {file_val[3:0], file_val[7:4]};
    end else begin
      result = diff[SST_DATA_W-1:0];
    end
    carry           = diff[SST_DATA_W];
    half_carry_flag = low_diff[4];
    zero            = (diff[SST_DATA_W-1:0] == 8'h00);
  end
endmodule

// file: dv/sst_chk.sv
`timescale 1ns/1ps
module sst_chk
  import sst_pkg::*;
#(
  parameter int FILE_DEPTH = 128
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic       done;
  logic [3:0] wix;
  assign done = avs_read && !avs_waitrequest;
  assign wix  = avs_address[5:2];
  ////////////////////////////////////////////////////////////
  // one instruction cycle of four clocks, no trailing bubble
  property p_exec;
    $rose(avs_write) && wix == SST_REG_INSTR |-> avs_waitrequest[*5] ##1 !avs_waitrequest;
  endproperty
  a_exec: assert property (p_exec) else $error("exec length wrong");
  property p_pulse;
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_pulse: assert property (p_pulse) else $error("wait low too long");
  property p_req;
    !avs_waitrequest |-> avs_read || avs_write;
  endproperty
  a_req: assert property (p_req) else $error("answer without request");
  property p_rdlat;
    $rose(avs_read) |-> ##[1:2] done;
  endproperty
  a_rdlat: assert property (p_rdlat) else $error("read answer late");
  property p_unmap;
    done && wix inside {[4'h5:4'h7]} |-> avs_readdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_faddr;
    done && wix == SST_REG_FADDR |-> avs_readdata[31:SST_FA_W] == '0;
  endproperty
  a_faddr: assert property (p_faddr) else $error("address wider than 7");
  property p_stat;
    done && wix == SST_REG_STATUS |-> avs_readdata[31:5] == '0;
  endproperty
  a_stat: assert property (p_stat) else $error("status high bits set");
  property p_rdchg;
    $changed(avs_readdata) |-> $past(avs_read);
  endproperty
  a_rdchg: assert property (p_rdchg) else $error("readdata moved");
endmodule

// file: dv/sst_host.sv
`timescale 1ns/1ps
module sst_host (
  input  wire logic        clk,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic      [5:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata
);
  initial begin
    avs_address   = 6'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
  end
  ////////////////////////////////////////////////////////////
  // direction regs written directly; legacy load only when a test means it
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = avs_readdata;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    // stale data would hide a late sample
    avs_writedata <= ~d;
    @(posedge clk);
  endtask
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
module tb
  import sst_pkg::*;
;
  logic        clk;
  logic        rst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] q;
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  sst_host host (.clk(clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata));
  sst_execute #(.FILE_DEPTH(128)) uut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask
  task close_out;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic [10:0] f_sub(input logic [7:0] f, input logic [7:0] w);
    logic [7:0] r;
    r = f - w;
    return {r == 8'h00, f[3:0] >= w[3:0], f >= w, r};
  endfunction
  // run is under two thousand cycles; ceiling leaves wide margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    logic [7:0]  f, w, g;
    logic [6:0]  a;
    logic [2:0]  s;
    logic        d, sw;
    logic [10:0] e;
    logic [5:0]  da;
    rst = 1'b1;
    void'($urandom(31));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(6'h04);
    chk(q, 32'h0);
    rd(6'h14);
    chk(q, 32'h0);
    for (int i = 0; i < 40; i++) begin
      f = $urandom;
      w = $urandom;
      g = $urandom;
      a = $urandom;
      d = $urandom;
      s = $urandom;
      sw = (i >= 20);
      // borrow corners: positive, zero, negative
      if (i < 3) begin
        f = 8'h03 - 8'(i);
        w = 8'h02;
      end
      if (i == 3 || i == 4) begin
        a = {7{i[0]}};
      end
      e = sw ? {s, f[3:0], f[7:4]} : f_sub(f, w);
      wr(6'h0C, {25'h0, a ^ 7'h01});
      wr(6'h10, {24'h0, g});
      wr(6'h04, {24'h0, w});
      wr(6'h0C, {25'h0, a});
      wr(6'h10, {24'h0, f});
      wr(6'h08, {29'h0, s});
      wr(6'h00, {18'h0, sw ? SST_OP_SWAP : SST_OP_SUB, d, a});
      rd(6'h04);
      chk(q, {24'h0, d ? w : e[7:0]});
      rd(6'h10);
      chk(q, {24'h0, d ? e[7:0] : f});
      rd(6'h08);
      chk(q, {29'h0, e[10:8]});
      wr(6'h0C, {25'h0, a ^ 7'h01});
      rd(6'h10);
      chk(q, {24'h0, g});
    end
    // reserved opcode: nothing moves but the illegal bit
    w = $urandom;
    s = $urandom;
    wr(6'h04, {24'h0, w});
    wr(6'h08, {29'h0, s});
    wr(6'h00, {18'h0, 6'h07, 8'($urandom)});
    rd(6'h04);
    chk(q, {24'h0, w});
    rd(6'h08);
    chk(q, {27'h0, 2'b10, s});
    for (int k = 0; k < 8; k++) begin
      w = $urandom;
      s = $urandom;
      da = 6'h20 + 6'(4 * k);
      rd(da);
      chk(q, 32'hFF);
      wr(6'h04, {24'h0, w});
      wr(6'h08, {29'h0, s});
      wr(6'h00, {18'h0, SST_OP_DIR, k[2:0]});
      rd(da);
      chk(q, {24'h0, w});
      rd(6'h08);
      chk(q, {29'h0, s});
      wr(da, {24'h0, ~w});
      rd(da);
      chk(q, {24'h0, ~w});
    end
    // second reset in mid-run: acc, status and direction regs back to their start values (file registers keep theirs)
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(6'h04);
    chk(q, 32'h0);
    rd(6'h08);
    chk(q, 32'h0);
    rd(6'h20);
    chk(q, {24'h0, SST_DIR_RST});
    close_out;
  end
endmodule

bind sst_execute sst_chk #(.FILE_DEPTH(FILE_DEPTH)) u_chk (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest));
